// >>> design/pio_cfg.svh
// constants for the programmable i/o port: reset values and group size
// assumes inclusion by bare name from package or modules
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH
`define PIO_GROUP_SIZE      4
`define PIO_DIR_RESET       1'B0
`define PIO_VALUE_RESET     1'B0
`define PIO_PULLUP_RESET    1'B0
`define PIO_SYNC_RESET      1'B0
`endif

// >>> design/pio_pkg.sv
// types shared by the programmable i/o port modules
// assumes pio_cfg.svh is on the include path
`include "pio_cfg.svh"
package pio_pkg;
    // =============================================================
    // register select codes
    typedef enum logic [1:0] {
        PIO_SEL_DIR    = 2'H0,
        PIO_SEL_VALUE  = 2'H1,
        PIO_SEL_PULLUP = 2'H2,
        PIO_SEL_NONE   = 2'H3
    } pio_sel_t;
endpackage

// >>> design/pio_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous to clock
`include "pio_cfg.svh"
module pio_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // =============================================================
    // stages
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_reg <= {WIDTH{`PIO_SYNC_RESET}};
            sync_reg <= {WIDTH{`PIO_SYNC_RESET}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// >>> design/pio_port.sv
// programmable i/o port: direction, output latch, grouped pull-ups
// assumes a local write/read port on the system clock; pins are external
// Functional notes
// - each line is set to input or output individually by its direction bit
// - pull-up enable is controlled per group of four adjacent lines
// - peripheral output enable turns on the driver regardless of direction bit
// - one direction bit per line; 0 means input
// - input line reads pin level; writes only update the output latch
// - output line reads back the output latch, not the pin
// - latch value drives the pin whenever the line is an output and its periph_oe bit is 0; with periph_oe 1 periph_out drives
// - one data bit per line for both writes and reads
// - pull-up active only for direction 0 lines with group select 1
// - pull-up ignores whether a peripheral or the port uses the pin
`include "pio_cfg.svh"
module pio_port #(
    parameter int LINES = 8
) (
    // clock and reset
    input  wire logic                                 clock,
    input  wire logic                                 nrst,
    // local register access
    input  wire logic                                 wr_en,
    input  wire pio_pkg::pio_sel_t                    wr_sel,
    input  wire logic [LINES-1:0]                     wr_data,
    input  wire pio_pkg::pio_sel_t                    rd_sel,
    output logic      [LINES-1:0]                     rd_data,
    // peripheral takeover
    input  wire logic [LINES-1:0]                     periph_oe,
    input  wire logic [LINES-1:0]                     periph_out,
    output logic      [LINES-1:0]                     periph_in,
    // pins
    input  wire logic [LINES-1:0]                     pin_in,
    output logic      [LINES-1:0]                     pin_out,
    output logic      [LINES-1:0]                     pin_oe,
    output logic      [LINES-1:0]                     pullup_en
);
    localparam int GROUPS = LINES / `PIO_GROUP_SIZE;

    // =============================================================
    // parameter check
    initial begin
        if (LINES < `PIO_GROUP_SIZE || (LINES % `PIO_GROUP_SIZE) != 0) begin
            $error("pio_port: LINES must be a positive multiple of the group size");
        end
    end

    // =============================================================
    // registers
    logic [LINES-1:0]  line_direction_reg;
    logic [LINES-1:0]  port_value_reg;
    logic [GROUPS-1:0] pullup_select_reg;
    logic [LINES-1:0]  rd_data_reg;
    logic [LINES-1:0]  rd_data_next;
    logic [LINES-1:0]  pin_sync;

    wire wr_dir    = wr_en && (wr_sel == pio_pkg::PIO_SEL_DIR);
    wire wr_value  = wr_en && (wr_sel == pio_pkg::PIO_SEL_VALUE);
    wire wr_pullup = wr_en && (wr_sel == pio_pkg::PIO_SEL_PULLUP);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            line_direction_reg <= {LINES{`PIO_DIR_RESET}};
            port_value_reg     <= {LINES{`PIO_VALUE_RESET}};
            pullup_select_reg  <= {GROUPS{`PIO_PULLUP_RESET}};
            rd_data_reg        <= '0;
        end else begin
            if (wr_dir) begin
                line_direction_reg <= wr_data;
            end
            if (wr_value) begin
                port_value_reg <= wr_data;
            end
            if (wr_pullup) begin
                pullup_select_reg <= wr_data[GROUPS-1:0];
            end
            rd_data_reg <= rd_data_next;
        end
    end

    // =============================================================
    // pin sampling
    pio_sync #(
        .WIDTH    (LINES)
    ) u_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // =============================================================
    // read path: per line, pin level for inputs, latch for outputs
    wire [LINES-1:0] value_view = (line_direction_reg & port_value_reg)
                                | (~line_direction_reg & pin_sync);
    wire [LINES-1:0] pullup_view;

    assign pullup_view = {{(LINES-GROUPS){1'B0}}, pullup_select_reg};

    always_comb begin
        rd_data_next = '0;
        unique case (rd_sel)
            pio_pkg::PIO_SEL_DIR:    rd_data_next = line_direction_reg;
            pio_pkg::PIO_SEL_VALUE:  rd_data_next = value_view;
            pio_pkg::PIO_SEL_PULLUP: rd_data_next = pullup_view;
            pio_pkg::PIO_SEL_NONE:   rd_data_next = '0;
        endcase
    end

    assign rd_data = rd_data_reg;

    // peripheral inputs see the synchronised pin; software keeps direction 0 for them
    assign periph_in = pin_sync;

    // =============================================================
    // pin drive and pull-ups
    assign pin_oe  = line_direction_reg | periph_oe;
    assign pin_out = (periph_oe & periph_out) | (~periph_oe & port_value_reg);

    // pull-up looks only at select and direction, never at periph_oe
    genvar g;
    generate
        for (g = 0; g < LINES; g = g + 1) begin : g_pull
            assign pullup_en[g] = pullup_select_reg[g / `PIO_GROUP_SIZE]
                                & ~line_direction_reg[g];
        end
    endgenerate
endmodule

// >>> bench/pio_port_chk.sv
// pin, pull-up and read path checks for pio_port
// assumes binding into pio_port built with eight lines
// ====
// checker
module pio_port_chk #(parameter int LINES = 8) (
    // clock, reset, access
    input wire logic                    clock, nrst, wr_en,
    input wire pio_pkg::pio_sel_t       wr_sel, rd_sel,
    // data and pins
    input wire logic        [LINES-1:0] wr_data, rd_data, periph_oe, periph_out, periph_in,
    input wire logic        [LINES-1:0] pin_in, pin_out, pin_oe, pullup_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_pull_wr;
        wr_en && wr_sel == pio_pkg::PIO_SEL_PULLUP;
    endsequence
    a_dir_oe: assert property (wr_en && wr_sel == pio_pkg::PIO_SEL_DIR
        |=> pin_oe == ($past(wr_data) | periph_oe)) else $error("dir oe");
    a_periph_drv: assert property ((pin_oe & periph_oe) == periph_oe
        && ((pin_out ^ periph_out) & periph_oe) == '0) else $error("periph");
    a_latch_out: assert property (wr_en && wr_sel == pio_pkg::PIO_SEL_VALUE
        |=> ((pin_out ^ $past(wr_data)) & ~periph_oe) == '0) else $error("latch");
    a_pull_dir: assert property ((pullup_en & pin_oe & ~periph_oe) == '0)
        else $error("pull dir");
    a_pull_grp: assert property (s_pull_wr |=> ((pullup_en
        ^ {{4{$past(wr_data[1])}}, {4{$past(wr_data[0])}}}) & ~pin_oe) == '0) else $error("grp");
    a_sync_in: assert property ($past(nrst) && $past(nrst, 2)
        |-> periph_in == $past(pin_in, 2)) else $error("sync");
    a_read_pin: assert property ($past(rd_sel == pio_pkg::PIO_SEL_VALUE)
        |-> ((rd_data ^ $past(periph_in)) & ~$past(pin_oe)) == '0) else $error("rd pin");
    a_read_latch: assert property ($past(rd_sel == pio_pkg::PIO_SEL_VALUE)
        |-> ((rd_data ^ $past(pin_out)) & $past(pin_oe & ~periph_oe)) == '0) else $error("rd l");
endmodule
bind pio_port pio_port_chk #(.LINES(LINES)) u_chk (.*);

// >>> bench/pio_pins_model.sv
// external devices and pull-ups on the eight port pins
// assumes ext_drv only on lines the port does not drive
module pio_pins_model (
    // clock, port pin drive and pull-ups, external drive
    input wire logic       clock,
    input wire logic [7:0] pin_out, pin_oe, pullup_en, ext_drv, ext_val,
    // sensed levels
    output logic     [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] float_q = 8'H00;
    // a floating line toggles so a stale level never passes
    always @(posedge clock) float_q <= ~float_q;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
        | (~pin_oe & ~ext_drv & (pullup_en | float_q));
endmodule

// >>> bench/pio_port_test.sv
// self-checking bench for pio_port with a pin model
// assumes eight lines and a 50 ns clock
module pio_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, nrst = 0, wr_en = 0;
    pio_pkg::pio_sel_t wr_sel = pio_pkg::PIO_SEL_NONE, rd_sel = pio_pkg::PIO_SEL_NONE;
    logic [7:0] wr_data = '0, periph_oe = '0, periph_out = '0, ext_drv = '0, ext_val = '0;
    logic [7:0] rd_data, periph_in, pin_in, pin_out, pin_oe, pullup_en;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    always #25 clock = ~clock;
    pio_port #(.LINES(8)) u_dut (.*);
    pio_pins_model u_pins (.*);
    task automatic cmp(input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input pio_pkg::pio_sel_t s, input logic [7:0] d);
        @(negedge clock) wr_en = 1;
        wr_sel = s;
        wr_data = d;
        @(negedge clock) wr_en = 0;
    endtask
    task automatic rd(input pio_pkg::pio_sel_t s, input logic [7:0] exp);
        @(negedge clock) rd_sel = s;
        @(negedge clock) cmp(rd_data, exp);
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock) if (++cycles > 2000) begin
        n_mismatch++;
        close_out();
    end
    task automatic t_output;
        wr(pio_pkg::PIO_SEL_DIR, 8'HFF);
        wr(pio_pkg::PIO_SEL_VALUE, 8'HA5);
        cmp(pin_oe, 8'HFF);
        cmp(pin_out, 8'HA5);
        rd(pio_pkg::PIO_SEL_VALUE, 8'HA5);
    endtask
    task automatic t_input;
        wr(pio_pkg::PIO_SEL_DIR, 8'H0F);
        ext_drv = 8'HF0;
        ext_val = 8'H50;
        wr(pio_pkg::PIO_SEL_VALUE, 8'H3C);
        repeat (3) @(negedge clock);
        cmp(periph_in, 8'H5C);
        rd(pio_pkg::PIO_SEL_VALUE, 8'H5C);
    endtask
    task automatic t_periph;
        ext_drv = 8'H00;
        periph_oe = 8'H11;
        periph_out = 8'H10;
        wr(pio_pkg::PIO_SEL_PULLUP, 8'HFF);
        cmp(pullup_en, 8'HF0);
        cmp(pin_oe, 8'H1F);
        cmp(pin_out, 8'H3C);
        rd(pio_pkg::PIO_SEL_PULLUP, 8'H03);
        repeat (2) @(negedge clock);
        rd(pio_pkg::PIO_SEL_VALUE, 8'HFC);
        wr(pio_pkg::PIO_SEL_NONE, 8'H00);
        wr(pio_pkg::PIO_SEL_PULLUP, 8'H01);
        rd(pio_pkg::PIO_SEL_DIR, 8'H0F);
        cmp(pullup_en, 8'H00);
    endtask
    task automatic t_reset;
        periph_oe = 8'H00;
        periph_out = 8'H00;
        @(negedge clock) nrst = 0;
        @(negedge clock) nrst = 1;
        cmp(pin_oe, 8'H00);
        cmp(pullup_en, 8'H00);
        cmp(rd_data, 8'H00);
    endtask
    initial begin
        repeat (6) @(negedge clock);
        nrst = 1;
        t_output();
        t_input();
        t_periph();
        t_reset();
        close_out();
    end
endmodule
